//--- inc/arp_pkg.sv
package arp_pkg;

	localparam int          DATA_W       = 16;
	localparam int          TAG_W        = DATA_W + 1;
	localparam int          FIFO_DEPTH   = 16;
	localparam int          LEVEL_W      = 5;
	localparam logic [4:0]  BITS_LAST    = 5'h0f;

	// Byte addresses on the register bus
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_STATUS   = 4'h4;

	localparam int          CTRL_EN_BIT  = 0;
	localparam logic [31:0] CTRL_RESET   = 32'h00000001;

	localparam int          ST_MODE_LSB  = 0;
	localparam int          ST_STANDBY   = 2;
	localparam int          ST_SHUTDOWN  = 3;
	localparam int          ST_OSR_LSB   = 4;
	localparam int          ST_LEVEL_LSB = 7;
	localparam int          ST_BUSY      = 12;
	localparam int          ST_HALF      = 13;

	// Pin synchroniser lanes
	localparam int          PIN_W        = 11;
	localparam int          P_FRAME_N    = 0;
	localparam int          P_STROBE_N   = 1;
	localparam int          P_KIND       = 2;
	localparam int          P_BYTESEL    = 3;
	localparam int          P_HBF        = 4;
	localparam int          P_PD         = 5;
	localparam int          P_RANGE      = 6;
	localparam int          P_TRIG       = 7;
	localparam int          P_OS_LSB     = 8;

	typedef enum logic [1:0] {
		ARP_MODE_PAR  = 2'b00,
		ARP_MODE_BYTE = 2'b01,
		ARP_MODE_SER  = 2'b10
	} arp_mode_t;

	typedef enum logic {
		ARP_LD_IDLE   = 1'b0,
		ARP_LD_SECOND = 1'b1
	} arp_load_t;

	function automatic arp_mode_t arpModeOf(input logic kind,
		input logic byteSel);
		if (!kind)
			return ARP_MODE_PAR;
		else if (byteSel)
			return ARP_MODE_BYTE;
		else
			return ARP_MODE_SER;
	endfunction : arpModeOf

endpackage : arp_pkg

//--- logic/arp_fifo.sv
`timescale 1ns/1ps
module arp_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	input  wire logic                       clkEn,
	input  wire logic                       inValid,
	output logic                            inReady,
	input  wire logic [WIDTH-1:0]           inData,
	output logic                            outValid,
	input  wire logic                       outReady,
	output logic [WIDTH-1:0]                outData,
	output logic [$clog2(DEPTH):0]          level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [AW:0]      count_q, count_d;
	logic             push, pop;

	assign inReady  = (count_q != DEPTH[AW:0]);
	assign outValid = (count_q != '0);
	assign outData  = mem_q[rdPtr_q];
	assign level    = count_q;

	always_comb begin
		push    = inValid && inReady;
		pop     = outValid && outReady;
		wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
		rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
		count_d = count_q;
		if (push && !pop)
			count_d = count_q + 1'b1;
		else if (pop && !push)
			count_d = count_q - 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (clkEn) begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clkEn && push)
			mem_q[wrPtr_q] <= inData;
	end

endmodule : arp_fifo

//--- logic/arp_output_port.sv
// Functional notes
// - Powerdown request enters standby or shutdown, chosen by range level.
// - Three oversample select lines decode, line 2 most significant.
// - Kind select low: bus driven only while frame and strobe low.
// - Full parallel mode: bus line n carries result bit n.
// - Kind select high: byte select low gives serial, high gives byte mode.
// - Bus line 15 becomes the byte select input when kind select high.
// - Bus line 14 becomes the high-byte-first input in byte mode.
// - High-byte-first 1 sends upper byte first, 0 sends lower byte first.
// - Byte mode: two strobes per result on lines 7..0, line 7 MSB.
// - Serial mode: two serial outputs shift out conversion data.
// - Frame fall presents MSB; each shift clock rise presents next bit.
// - First flag tristate while frame high, cleared next strobe fall; serial mode clears it only at the 16th strobe fall after frame fall.
// - Sample trigger rising edges are ignored while busy is high.
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module arp_output_port
	import arp_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	input  wire logic                clkEn,
	input  wire logic [3:0]          avsAddress,
	input  wire logic                avsRead,
	input  wire logic                avsWrite,
	input  wire logic [31:0]         avsWriteData,
	output logic [31:0]              avsReadData,
	output logic                     avsWaitrequest,
	input  wire logic                resultValid,
	output logic                     resultReady,
	input  wire logic [DATA_W-1:0]   resultData,
	input  wire logic                resultFirst,
	input  wire logic                busy,
	output logic                     convStart,
	input  wire logic                sampleTrigger,
	input  wire logic                frameSelect_n,
	input  wire logic                readStrobe_n,
	input  wire logic                interfaceKindSelect,
	input  wire logic [DATA_W-1:0]   resultBusIn,
	output logic [DATA_W-1:0]        resultBusOut,
	output logic [DATA_W-1:0]        resultBusOe,
	output logic                     serialOutFirst,
	output logic                     serialOutSecond,
	output logic                     serialOe,
	output logic                     firstChannelFlag,
	output logic                     firstChannelFlagOe,
	input  wire logic                powerdownRequest,
	input  wire logic                rangeSelect,
	input  wire logic [2:0]          oversampleRatioSelect,
	output logic                     standbyMode,
	output logic                     shutdownMode,
	output logic [2:0]               oversampleRatio
);
	logic [PIN_W-1:0]  pinMeta_q, pinSync_q, pinRaw;
	logic [2:0]        prev_q;
	logic              frameLow, strobeLow, frameFall, strobeFall, strobeRise;
	logic              trigRise, frameHeld, strobeHeld;
	arp_mode_t         mode_q, mode_d;

	logic [DATA_W-1:0] word_q, word_d, wordB_q, wordB_d;
	logic [DATA_W-1:0] busOut_q, busOut_d;
	logic              first_q, first_d, half_q, half_d;
	logic [4:0]        riseCnt_q, riseCnt_d, fallCnt_q, fallCnt_d;
	arp_load_t         ld_q, ld_d;
	logic              popReady, popValid;
	logic [TAG_W-1:0]  popData;
	logic [LEVEL_W-1:0] level;
	logic              showHigh;

	logic              standby_d, shutdown_d, convStart_d;
	logic [2:0]        osr_d;

	logic [31:0]       ctrl_q, ctrl_d, rdData_q, rdData_d, status;
	logic              ack_q, ack_d, portEn;

	assign pinRaw = {oversampleRatioSelect, sampleTrigger, rangeSelect,
		powerdownRequest, resultBusIn[14], resultBusIn[15],
		interfaceKindSelect, readStrobe_n, frameSelect_n};

	// Pins cross in through two flops; only the second stage is read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta_q <= 11'h003;
			pinSync_q <= 11'h003;
			prev_q    <= 3'h3;
		end else if (clkEn) begin
			pinMeta_q <= pinRaw;
			pinSync_q <= pinMeta_q;
			prev_q    <= {pinSync_q[P_TRIG], pinSync_q[P_STROBE_N],
				pinSync_q[P_FRAME_N]};
		end
	end

	assign frameLow   = !pinSync_q[P_FRAME_N];
	assign strobeLow  = !pinSync_q[P_STROBE_N];
	assign frameFall  = frameLow && prev_q[0];
	assign strobeFall = strobeLow && prev_q[1];
	assign strobeRise = !strobeLow && !prev_q[1];
	assign trigRise   = pinSync_q[P_TRIG] && !prev_q[2];
	assign frameHeld  = frameLow && !prev_q[0];
	assign strobeHeld = strobeLow && !prev_q[1];
	assign portEn     = ctrl_q[CTRL_EN_BIT];

	arp_fifo #(
		.WIDTH (TAG_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.inValid  (resultValid),
		.inReady  (resultReady),
		.inData   ({resultFirst, resultData}),
		.outValid (popValid),
		.outReady (popReady),
		.outData  (popData),
		.level    (level)
	);

	// Data path of the host port
	always_comb begin
		mode_d    = arpModeOf(pinSync_q[P_KIND], pinSync_q[P_BYTESEL]);
		word_d    = word_q;
		wordB_d   = wordB_q;
		first_d   = first_q;
		half_d    = half_q;
		riseCnt_d = riseCnt_q;
		fallCnt_d = fallCnt_q;
		ld_d      = ld_q;
		popReady  = 1'b0;
		case (mode_q)
			ARP_MODE_PAR: begin
				if (frameLow && strobeFall) begin
					popReady = 1'b1;
					word_d   = popValid ? popData[DATA_W-1:0] : '0;
					first_d  = popValid && popData[DATA_W];
				end
			end
			ARP_MODE_BYTE: begin
				if (frameLow && strobeFall) begin
					if (!half_q) begin
						popReady = 1'b1;
						word_d   = popValid ? popData[DATA_W-1:0] : '0;
						first_d  = popValid && popData[DATA_W];
						half_d   = 1'b1;
					end else begin
						half_d  = 1'b0;
						first_d = 1'b0;
					end
				end
			end
			ARP_MODE_SER: begin
				if (ld_q == ARP_LD_SECOND) begin
					popReady = 1'b1;
					wordB_d  = popValid ? popData[DATA_W-1:0] : '0;
					ld_d     = ARP_LD_IDLE;
				end else if (frameFall || (frameLow && strobeRise &&
					riseCnt_q == BITS_LAST)) begin
					popReady  = 1'b1;
					word_d    = popValid ? popData[DATA_W-1:0] : '0;
					first_d   = popValid && popData[DATA_W];
					ld_d      = ARP_LD_SECOND;
					riseCnt_d = '0;
					fallCnt_d = '0;
				end else if (frameLow && strobeRise) begin
					word_d    = {word_q[DATA_W-2:0], 1'b0};
					wordB_d   = {wordB_q[DATA_W-2:0], 1'b0};
					riseCnt_d = riseCnt_q + 5'h01;
				end
				if (frameLow && strobeFall && ld_q == ARP_LD_IDLE) begin
					fallCnt_d = fallCnt_q + 5'h01;
					if (fallCnt_q == BITS_LAST)
						first_d = 1'b0;
				end
			end
			default: begin
				ld_d = ARP_LD_IDLE;
			end
		endcase
		showHigh = pinSync_q[P_HBF] ? half_d : !half_d;
		if (mode_q == ARP_MODE_BYTE)
			busOut_d = {8'h00, showHigh ? word_d[15:8] : word_d[7:0]};
		else
			busOut_d = word_d;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q    <= ARP_MODE_PAR;
			word_q    <= '0;
			wordB_q   <= '0;
			busOut_q  <= '0;
			first_q   <= 1'b0;
			half_q    <= 1'b0;
			riseCnt_q <= '0;
			fallCnt_q <= '0;
			ld_q      <= ARP_LD_IDLE;
		end else if (clkEn) begin
			mode_q    <= mode_d;
			word_q    <= word_d;
			wordB_q   <= wordB_d;
			busOut_q  <= busOut_d;
			first_q   <= first_d;
			half_q    <= half_d;
			riseCnt_q <= riseCnt_d;
			fallCnt_q <= fallCnt_d;
			ld_q      <= ld_d;
		end
	end

	// Enables wait one cycle after the edge so fresh data is on the pins
	always_comb begin
		resultBusOe = '0;
		if (portEn && frameHeld && strobeHeld) begin
			if (mode_q == ARP_MODE_PAR)
				resultBusOe = 16'hffff;
			else if (mode_q == ARP_MODE_BYTE)
				resultBusOe = 16'h00ff;
		end
	end
	assign resultBusOut       = busOut_q;
	assign serialOe           = portEn && frameHeld &&
		mode_q == ARP_MODE_SER;
	assign serialOutFirst     = word_q[DATA_W-1];
	assign serialOutSecond    = wordB_q[DATA_W-1];
	assign firstChannelFlag   = first_q;
	assign firstChannelFlagOe = portEn && frameHeld;

	// Static pins and trigger gating
	always_comb begin
		standby_d   = pinSync_q[P_PD] && !pinSync_q[P_RANGE];
		shutdown_d  = pinSync_q[P_PD] && pinSync_q[P_RANGE];
		osr_d       = pinSync_q[P_OS_LSB+2:P_OS_LSB];
		convStart_d = trigRise && !busy;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			standbyMode     <= 1'b0;
			shutdownMode    <= 1'b0;
			oversampleRatio <= 3'h0;
			convStart       <= 1'b0;
		end else if (clkEn) begin
			standbyMode     <= standby_d;
			shutdownMode    <= shutdown_d;
			oversampleRatio <= osr_d;
			convStart       <= convStart_d;
		end
	end

	// Register slave: one wait cycle, then the answer
	always_comb begin
		status = '0;
		status[ST_MODE_LSB+1:ST_MODE_LSB]   = mode_q;
		status[ST_STANDBY]                  = standbyMode;
		status[ST_SHUTDOWN]                 = shutdownMode;
		status[ST_OSR_LSB+2:ST_OSR_LSB]     = oversampleRatio;
		status[ST_LEVEL_LSB+4:ST_LEVEL_LSB] = level;
		status[ST_BUSY]                     = busy;
		status[ST_HALF]                     = half_q;
		ack_d    = (avsRead || avsWrite) && !ack_q;
		ctrl_d   = ctrl_q;
		rdData_d = rdData_q;
		if (ack_d && avsRead) begin
			case (avsAddress)
				REG_CTRL:   rdData_d = ctrl_q;
				REG_STATUS: rdData_d = status;
				default:    rdData_d = '0;
			endcase
		end
		if (ack_q && avsWrite && avsAddress == REG_CTRL)
			ctrl_d = {31'h00000000, avsWriteData[CTRL_EN_BIT]};
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q   <= CTRL_RESET;
			rdData_q <= '0;
			ack_q    <= 1'b0;
		end else if (clkEn) begin
			ctrl_q   <= ctrl_d;
			rdData_q <= rdData_d;
			ack_q    <= ack_d;
		end
	end

	assign avsWaitrequest = (avsRead || avsWrite) && !ack_q;
	assign avsReadData    = rdData_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_power_mode:
	assert property (clkEn && pinSync_q[P_PD] && !pinSync_q[P_RANGE]
		|=> standbyMode && !shutdownMode)
		else $error("standby not entered");
	a_osr_decode:
	assert property (clkEn |=> oversampleRatio ==
		$past(pinSync_q[P_OS_LSB+2:P_OS_LSB]))
		else $error("oversample select misdecoded");
	a_bus_gate:
	assert property (resultBusOe != '0 |-> frameLow && strobeLow &&
		!pinSync_q[P_KIND] == (mode_q == ARP_MODE_PAR))
		else $error("bus driven outside frame and strobe");
	a_word_map:
	assert property (mode_q == ARP_MODE_PAR && resultBusOe != '0
		|-> resultBusOut == word_q)
		else $error("parallel word misplaced");
	a_pin_input:
	assert property (mode_q != ARP_MODE_PAR
		|-> !resultBusOe[15] && !resultBusOe[14])
		else $error("select pins driven");
	a_byte_order:
	assert property (mode_q == ARP_MODE_BYTE && resultBusOe != '0 &&
		half_q && pinSync_q[P_HBF] && $stable(pinSync_q[P_HBF])
		|-> resultBusOut[7:0] == word_q[15:8])
		else $error("first byte wrong");
	a_byte_pair:
	assert property (clkEn && popReady && mode_q == ARP_MODE_BYTE
		|-> !half_q ##1 half_q)
		else $error("byte mode advanced early");
	a_serial_msb:
	assert property (clkEn && mode_q == ARP_MODE_SER && frameFall &&
		ld_q == ARP_LD_IDLE |=> riseCnt_q == 5'h00 ##1 ld_q == ARP_LD_IDLE)
		else $error("serial frame start not loaded");
	a_first_hiz:
	assert property (!frameLow |-> !firstChannelFlagOe && !serialOe)
		else $error("flag driven while frame high");
	a_busy_ignore:
	assert property (busy |=> !convStart || !$past(busy))
		else $error("trigger accepted while busy");

endmodule : arp_output_port

//--- sim/arp_host_model.sv
`timescale 1ns/1ps
module arp_host_model #(
	parameter real HALF = 62.5
) (
	input  wire logic        sys_clk,
	input  wire logic [15:0] busWire,
	input  wire logic [15:0] busOe,
	input  wire logic        flagWire,
	input  wire logic        serA,
	input  wire logic        serB,
	output logic             frameSelect_n,
	output logic             readStrobe_n
);
	initial begin
		frameSelect_n = 1'b1;
		readStrobe_n  = 1'b1;
	end

	// Host pins run on their own time base; frame realigns to sys_clk
	task automatic frame(input logic open);
		frameSelect_n <= ~open;
		#(2.0 * HALF);
		@(posedge sys_clk);
	endtask : frame

	// One read strobe, sampled late in its low phase
	task automatic strobe(output logic [15:0] d, output logic [15:0] e,
		output logic f);
		readStrobe_n <= 1'b0;
		#(HALF - 10.0);
		d = busWire;
		e = busOe;
		f = flagWire;
		#10.0;
		readStrobe_n <= 1'b1;
		#(HALF);
	endtask : strobe

	// Frame fall gives the MSB, each shift clock rise the next bit
	task automatic shift(output logic [15:0] a, output logic [15:0] b);
		frameSelect_n <= 1'b0;
		#(HALF - 10.0);
		for (int i = 15; i >= 0; i--) begin
			a[i] = serA;
			b[i] = serB;
			if (i > 0) begin
				#10.0;
				readStrobe_n <= 1'b0;
				#(HALF);
				readStrobe_n <= 1'b1;
				#(HALF - 10.0);
			end
		end
		#10.0;
		frameSelect_n <= 1'b1;
		#(HALF);
		@(posedge sys_clk);
	endtask : shift
endmodule : arp_host_model

//--- sim/arp_testbench.sv
`timescale 1ns/1ps
module testbench;
	import arp_pkg::*;
	logic        sys_clk, rst_n, avsRead, avsWrite, avsWaitrequest, clkEn;
	logic [3:0]  avsAddress;
	logic [31:0] avsWriteData, avsReadData;
	logic        resultValid, resultReady, resultFirst, busy, convStart;
	logic [15:0] resultData, resultBusOut, resultBusOe, hostBus;
	logic        sampleTrigger, frameSelect_n, readStrobe_n, kindSel;
	logic        serA, serB, serialOe, flag, flagOe, pdReq, rangeSel;
	logic        standbyMode, shutdownMode;
	logic [2:0]  osrSel, oversampleRatio;
	logic [15:0] busWire;
	int          num_errors, checked, cycles, convCount;

	assign busWire = (resultBusOe & resultBusOut) | (~resultBusOe & hostBus);

	arp_output_port i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsReadData(avsReadData),
		.avsWaitrequest(avsWaitrequest), .resultValid(resultValid),
		.resultReady(resultReady), .resultData(resultData),
		.resultFirst(resultFirst), .busy(busy), .convStart(convStart),
		.sampleTrigger(sampleTrigger), .frameSelect_n(frameSelect_n),
		.readStrobe_n(readStrobe_n), .interfaceKindSelect(kindSel),
		.resultBusIn(busWire), .resultBusOut(resultBusOut),
		.resultBusOe(resultBusOe), .serialOutFirst(serA),
		.serialOutSecond(serB), .serialOe(serialOe),
		.firstChannelFlag(flag), .firstChannelFlagOe(flagOe),
		.powerdownRequest(pdReq), .rangeSelect(rangeSel),
		.oversampleRatioSelect(osrSel), .standbyMode(standbyMode),
		.shutdownMode(shutdownMode), .oversampleRatio(oversampleRatio)
	);

	arp_host_model i_host (
		.sys_clk(sys_clk), .busWire(busWire), .busOe(resultBusOe),
		.flagWire(flag & flagOe), .serA(serA & serialOe),
		.serB(serB & serialOe),
		.frameSelect_n(frameSelect_n), .readStrobe_n(readStrobe_n)
	);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (convStart === 1'b1) convCount++;
		if (cycles == 60000) begin
			num_errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	// Request held until waitrequest is sampled low
	task automatic av(input logic wr, input logic [3:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		avsAddress   <= a;
		avsWrite     <= wr;
		avsRead      <= ~wr;
		avsWriteData <= wd;
		@(posedge sys_clk);
		while (avsWaitrequest !== 1'b0)
			@(posedge sys_clk);
		rd = avsReadData;
		avsRead  <= 1'b0;
		avsWrite <= 1'b0;
		@(posedge sys_clk);
	endtask : av

	task automatic push(input logic [15:0] w, input logic f);
		resultValid <= 1'b1;
		resultData  <= w;
		resultFirst <= f;
		@(posedge sys_clk);
		while (resultReady !== 1'b1)
			@(posedge sys_clk);
		resultValid <= 1'b0;
		@(posedge sys_clk);
	endtask : push

	function automatic logic [15:0] wd(input int i);
		return (16'h0001 << i) ^ 16'hc35a;
	endfunction : wd

	task automatic t_regs();
		logic [31:0] d;
		av(1'b0, REG_CTRL, 32'h0, d);
		chk("ctrl reset", CTRL_RESET, d);
		av(1'b1, 4'h8, 32'hffffffff, d);
		av(1'b0, 4'h8, 32'h0, d);
		chk("unmapped", 32'h0, d);
	endtask : t_regs

	task automatic t_pins();
		logic [31:0] d;
		for (int i = 0; i < 8; i++) begin
			osrSel <= i[2:0];
			cyc(6);
			chk("osr", i, {29'h0, oversampleRatio});
			av(1'b0, REG_STATUS, 32'h0, d);
			chk("status osr", i, (d >> ST_OSR_LSB) & 32'h7);
		end
		for (int r = 0; r < 2; r++) begin
			pdReq    <= 1'b1;
			rangeSel <= r[0];
			cyc(6);
			chk("standby", {31'h0, ~r[0]}, {31'h0, standbyMode});
			chk("shutdown", {31'h0, r[0]}, {31'h0, shutdownMode});
			pdReq <= 1'b0;
			cyc(6);
			chk("awake", 32'h0, {30'h0, standbyMode, shutdownMode});
		end
	endtask : t_pins

	task automatic t_trig();
		int c;
		for (int b = 1; b >= 0; b--) begin
			c = convCount;
			busy          <= b[0];
			sampleTrigger <= 1'b1;
			cyc(8);
			sampleTrigger <= 1'b0;
			cyc(8);
			chk("conv starts", 1 - b, convCount - c);
		end
	endtask : t_trig

	task automatic t_par();
		logic [31:0] s;
		logic [15:0] d, e;
		logic        f;
		kindSel <= 1'b0;
		hostBus <= 16'ha5a5;
		for (int i = 0; i < 16; i++) push(wd(i), i == 0);
		chk("full refuses", 32'h0, {31'h0, resultReady});
		av(1'b0, REG_STATUS, 32'h0, s);
		chk("level", 16, (s >> ST_LEVEL_LSB) & 32'h1f);
		chk("mode par", ARP_MODE_PAR, s & 32'h3);
		i_host.frame(1'b1);
		for (int i = 0; i < 16; i++) begin
			i_host.strobe(d, e, f);
			chk("par data", wd(i), d);
			chk("par oe", 16'hffff, e);
			chk("first flag", i == 0, f);
		end
		chk("bus released", 32'h0, resultBusOe);
		i_host.frame(1'b0);
		chk("flag oe", 32'h0, flagOe);
	endtask : t_par

	task automatic t_byte();
		logic [31:0] s;
		logic [15:0] d1, d2, e, w;
		logic        f;
		kindSel <= 1'b1;
		for (int h = 0; h < 2; h++) begin
			hostBus <= {1'b1, h[0], 14'h0};
			push(wd(h + 3), 1'b0);
			push(wd(h + 9), 1'b0);
			av(1'b0, REG_STATUS, 32'h0, s);
			chk("mode byte", ARP_MODE_BYTE, s & 32'h3);
			i_host.frame(1'b1);
			for (int k = 0; k < 2; k++) begin
				w = wd(h + 3 + 6 * k);
				i_host.strobe(d1, e, f);
				i_host.strobe(d2, e, f);
				chk("byte a", h ? w[15:8] : w[7:0], d1[7:0]);
				chk("byte b", h ? w[7:0] : w[15:8], d2[7:0]);
				chk("byte oe", 32'h00ff, e);
			end
			i_host.frame(1'b0);
		end
	endtask : t_byte

	task automatic t_ser();
		logic [31:0] s;
		logic [15:0] a, b;
		hostBus <= 16'h0000;
		push(wd(5), 1'b1);
		push(wd(12), 1'b0);
		av(1'b0, REG_STATUS, 32'h0, s);
		chk("mode ser", ARP_MODE_SER, s & 32'h3);
		i_host.shift(a, b);
		chk("serial first", wd(5), a);
		chk("serial second", wd(12), b);
	endtask : t_ser

	task automatic t_off();
		logic [31:0] s;
		logic [15:0] d, e;
		logic        f;
		kindSel <= 1'b0;
		av(1'b1, REG_CTRL, 32'h0, s);
		push(wd(7), 1'b0);
		i_host.frame(1'b1);
		i_host.strobe(d, e, f);
		chk("disabled oe", 32'h0, e);
		i_host.frame(1'b0);
		av(1'b1, REG_CTRL, CTRL_RESET, s);
	endtask : t_off

	// Clock enable low must freeze every stage
	task automatic t_freeze();
		clkEn  <= 1'b0;
		osrSel <= 3'h2;
		cyc(6);
		chk("osr frozen", 32'h7, {29'h0, oversampleRatio});
		clkEn <= 1'b1;
		cyc(6);
		chk("osr resumes", 32'h2, {29'h0, oversampleRatio});
	endtask : t_freeze

	// Reset in mid-run empties the queue and restores the enable
	task automatic t_reset();
		logic [31:0] s;
		av(1'b1, REG_CTRL, 32'h0, s);
		push(wd(2), 1'b0);
		rst_n <= 1'b0;
		cyc(2);
		chk("ready in reset", 32'h1, {31'h0, resultReady});
		rst_n <= 1'b1;
		@(posedge sys_clk);
		av(1'b0, REG_STATUS, 32'h0, s);
		chk("level after reset", 32'h0, (s >> ST_LEVEL_LSB) & 32'h1f);
		av(1'b0, REG_CTRL, 32'h0, s);
		chk("ctrl after reset", CTRL_RESET, s);
	endtask : t_reset

	initial begin
		rst_n = 1'b0;
		{avsRead, avsWrite, resultValid, resultFirst, busy} = 5'h00;
		{sampleTrigger, kindSel, pdReq, rangeSel} = 4'h0;
		clkEn = 1'b1;
		avsAddress = 4'h0;
		avsWriteData = 32'h0;
		resultData = 16'h0000;
		hostBus = 16'ha5a5;
		osrSel = 3'h0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		t_pins();
		t_trig();
		t_par();
		t_byte();
		t_ser();
		t_off();
		t_freeze();
		t_reset();
		stop_test();
	end
endmodule : testbench
